// File: hw/dme_entry_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module dme_entry_ctrl
  import dme_pkg::*;
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rst,
  // breakpoint request pin, shared by external and on-chip requesters
  input  wire logic          breakpoint_request_n,
  // core and bus events
  input  wire dme_core_evt_t core,
  input  wire dme_bus_evt_t  bus,
  // trace controls from the status register
  input  wire logic          trace_enable,
  input  wire logic          trace_flow_only,
  // resume command decoded by the serial command engine
  input  wire logic          resume_cmd,
  // core control
  output logic               exec_suspend,
  output logic               fetch_enable,
  output logic               breakpoint_request_n_ack_cycle,
  output dme_exc_t           exc,
  // debug status
  output logic               freeze,
  output logic               serial_enable,
  output logic               debug_enabled,
  output logic [31:0]        temp_address_reg,
  // pipeline tracking pins
  output logic               pipe_advance_flag,
  output logic               fetch_flush_flag
);

  logic       bp_sync_n;
  logic       bp_ack;
  logic       rst_seen;
  logic       next_rst_seen;
  logic       next_debug_enabled;
  dme_state_t state;
  dme_state_t next_state;
  logic [31:0] next_temp;
  dme_exc_t   next_exc;
  logic       next_ack_cycle;
  logic       next_pipe;
  logic       next_fetch;
  logic       is_background_entry_opcode;
  logic       is_soft_bp;
  logic       is_line_a;
  logic       is_line_f;

  // opcode class decode, shared by several decisions below
  function automatic logic in_range(input logic [15:0] op,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (op >= lo) && (op <= hi);
  endfunction

  // request pin is asynchronous to the core clock
  dme_sync u_bp_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in (breakpoint_request_n),
    .sync_out (bp_sync_n)
  );

  // external and peripheral requests arrive on one line, one path
  dme_bp_track u_bp_track (
    .clock  (clock),
    .rst    (rst),
    .bp_req (~bp_sync_n & (state == DME_RUN)),
    .bus    (bus),
    .bp_ack (bp_ack)
  );

  assign is_background_entry_opcode    = core.decode_valid && (core.opcode == OP_BACKGROUND);
  assign is_soft_bp = core.decode_valid && in_range(core.opcode, OP_SOFT_BREAKPOINT_REQUEST_N_LO, OP_SOFT_BREAKPOINT_REQUEST_N_HI);
  assign is_line_a  = core.decode_valid && in_range(core.opcode, 16'hA000, 16'hAFFF);
  assign is_line_f  = core.decode_valid && in_range(core.opcode, 16'hF000, 16'hFFFF);

  // enable latch: captured on the first clock after reset release, so the
  // flop itself resets to a constant and the pin level is taken clocked
  always_comb
  begin
    next_rst_seen      = 1'b1;
    next_debug_enabled = debug_enabled;
    if (!rst_seen)
      next_debug_enabled = ~bp_sync_n;            // low enables until next reset
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rst_seen      <= 1'b0;
      debug_enabled <= DEBUG_EN_RESET;
    end
    else
    begin
      rst_seen      <= next_rst_seen;
      debug_enabled <= next_debug_enabled;
    end
  end

  // entry source routing and the debug state machine
  always_comb
  begin
    next_state     = state;
    next_temp      = temp_address_reg;
    next_exc       = '0;
    next_ack_cycle = 1'b0;
    unique case (state)
      DME_RUN:
      begin
        if (core.double_fault)
        begin
          if (debug_enabled)
          begin
            next_state = DME_FREEZE;
            next_temp  = {core.fault_status_word, SRC_DBF_LOW};
          end
          else
            next_state = DME_HALTED;                                 // stop until reset
        end
        else if (bp_ack)
        begin
          if (debug_enabled)
          begin
            next_state = DME_FREEZE;                                 // no acknowledge cycle
            next_temp  = SRC_HW_CODE;
          end
          else
          begin
            next_ack_cycle = 1'b1;
            next_exc.take   = 1'b1;
            next_exc.vector = VEC_HW_BREAKPOINT;
          end
        end
        else if (is_background_entry_opcode)
        begin
          if (debug_enabled)
          begin
            next_state = DME_FREEZE;
            next_temp  = SRC_BACKGROUND_ENTRY_OPCODE_CODE;
          end
          else
          begin
            next_exc.take   = 1'b1;
            next_exc.vector = VEC_ILLEGAL;
          end
        end
        else if (is_soft_bp)
        begin
          // never a debug entry, whatever the enable says
          next_exc.take         = 1'b1;
          next_exc.vector       = VEC_ILLEGAL;
          next_exc.opcode_subst = 1'b1;
        end
        else if (is_line_a || is_line_f)
        begin
          next_exc.take   = 1'b1;
          next_exc.vector = is_line_a ? VEC_LINE_A : VEC_LINE_F;
        end
        else if (trace_enable && core.insn_done && (!trace_flow_only || core.flow_change))
        begin
          next_exc.take   = 1'b1;
          next_exc.vector = VEC_TRACE;
        end
      end
      DME_FREEZE:
        next_state = DME_SERIAL;                                     // halt shown before serial
      DME_SERIAL:
        if (resume_cmd)
          next_state = DME_RUN;
      DME_HALTED:
        next_state = DME_HALTED;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state            <= DME_RUN;
      temp_address_reg <= '0;
      exc              <= '0;
      breakpoint_request_n_ack_cycle   <= 1'b0;
    end
    else
    begin
      state            <= next_state;
      temp_address_reg <= next_temp;
      exc              <= next_exc;
      breakpoint_request_n_ack_cycle   <= next_ack_cycle;
    end
  end

  // status decode straight from the one-hot state
  assign freeze        = (state == DME_FREEZE) || (state == DME_SERIAL);
  assign serial_enable = (state == DME_SERIAL);
  assign exec_suspend  = (state != DME_RUN);
  // freeze drops with the return to run, and fetch restarts in that same cycle
  assign fetch_enable  = (state == DME_RUN);

  // tracking pins are registered; while serial owns the pins they hold low
  always_comb
  begin
    next_pipe  = 1'b0;
    next_fetch = 1'b0;
    if (next_state == DME_RUN)
    begin
      next_pipe  = core.insn_start || core.pipe_advance;
      next_fetch = (bus.cycle_end && bus.pipe_load) || bus.flush;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pipe_advance_flag <= 1'b0;
      fetch_flush_flag  <= 1'b0;
    end
    else
    begin
      pipe_advance_flag <= next_pipe;
      fetch_flush_flag  <= next_fetch;
    end
  end

endmodule
`default_nettype wire

// File: hw/dme_pkg.sv
package dme_pkg;

  // opcode decoding constants
  localparam logic [15:0] OP_BACKGROUND   = 16'h4AFA;
  localparam logic [15:0] OP_SOFT_BREAKPOINT_REQUEST_N_LO = 16'h4848;
  localparam logic [15:0] OP_SOFT_BREAKPOINT_REQUEST_N_HI = 16'h484F;

  // exception vectors; the two unimplemented-class vectors are plain defaults
  localparam logic [7:0] VEC_HW_BREAKPOINT = 8'h0C;
  localparam logic [7:0] VEC_ILLEGAL       = 8'h04;
  localparam logic [7:0] VEC_LINE_A        = 8'h0A;
  localparam logic [7:0] VEC_LINE_F        = 8'h0B;
  localparam logic [7:0] VEC_TRACE         = 8'h09;

  // entry-source codes written to the temporary register
  localparam logic [15:0] SRC_DBF_LOW   = 16'hFFFF;
  localparam logic [31:0] SRC_BACKGROUND_ENTRY_OPCODE_CODE = 32'h0000_0001;
  localparam logic [31:0] SRC_HW_CODE   = 32'h0000_0000;

  // reset values
  localparam logic       DEBUG_EN_RESET = 1'b0;
  localparam logic [1:0] SYNC_RESET     = 2'b11;

  // core controller states
  typedef enum logic [3:0] {
    DME_RUN    = 4'b0001,
    DME_FREEZE = 4'b0010,
    DME_SERIAL = 4'b0100,
    DME_HALTED = 4'b1000
  } dme_state_t;

  // instruction events from the core sequencer
  typedef struct packed {
    logic        decode_valid;
    logic [15:0] opcode;
    logic        insn_start;
    logic        pipe_advance;
    logic        insn_done;
    logic        flow_change;
    logic        double_fault;
    logic [15:0] fault_status_word;
  } dme_core_evt_t;

  // bus cycle tagging from the bus controller
  typedef struct packed {
    logic cycle_end;
    logic is_prefetch;
    logic pipe_load;
    logic flush;
  } dme_bus_evt_t;

  // exception request to the core
  typedef struct packed {
    logic       take;
    logic [7:0] vector;
    logic       opcode_subst;
  } dme_exc_t;

endpackage

// File: hw/dme_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dme_sync
  import dme_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // asynchronous level in, synchronised level out
  input  wire logic async_in,
  output logic      sync_out
);

  logic [1:0] stages;
  logic [1:0] next_stages;

  // the first stage feeds only the second
  always_comb
  begin
    next_stages = {stages[0], async_in};
  end

  // no reset on purpose: the stages must follow the pin while reset is held,
  // otherwise a level set up before release could never reach the enable latch
  always_ff @(posedge clock)
  begin
    stages <= next_stages;
  end

  assign sync_out = stages[1];

endmodule
`default_nettype wire

// File: hw/dme_bp_track.sv
`timescale 1ns/1ps
`default_nettype none
module dme_bp_track
  import dme_pkg::*;
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // synchronised breakpoint request, active high here
  input  wire logic         bp_req,
  input  wire dme_bus_evt_t bus,
  // acknowledged breakpoint, one-cycle pulse
  output logic              bp_ack
);

  logic pending;
  logic next_pending;
  logic next_ack;
  logic ack_q;

  // a prefetch tag is held until the pipeline either uses or flushes it
  always_comb
  begin
    next_pending = pending;
    next_ack     = 1'b0;
    if (bus.flush)
      next_pending = 1'b0;                        // flushed prefetch: ignored
    else if (pending && bus.pipe_load)
    begin
      next_ack     = 1'b1;
      next_pending = 1'b0;
    end
    if (bus.cycle_end && bp_req)
    begin
      if (bus.is_prefetch)
        next_pending = 1'b1;
      else
        next_ack = 1'b1;                          // operand tag always taken
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      pending <= 1'b0;
      ack_q   <= 1'b0;
    end
    else
    begin
      pending <= next_pending;
      ack_q   <= next_ack;
    end
  end

  assign bp_ack = ack_q;

endmodule
`default_nettype wire

// File: sim/dme_entry_props.sv
`timescale 1ns/1ps
`default_nettype none
module dme_entry_props
  import dme_pkg::*;
(
  // clock and reset
  input wire logic          clock,
  input wire logic          rst,
  // core and bus events
  input wire dme_core_evt_t core,
  input wire dme_bus_evt_t  bus,
  // watched outputs
  input wire logic          exec_suspend,
  input wire logic          fetch_enable,
  input wire logic          breakpoint_request_n_ack_cycle,
  input wire dme_exc_t      exc,
  input wire logic          freeze,
  input wire logic          serial_enable,
  input wire logic          debug_enabled,
  input wire logic [31:0]   temp_address_reg,
  input wire logic          pipe_advance_flag,
  input wire logic          fetch_flush_flag
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // opcode decoded while running, no fault outranking it
  wire logic op_run = fetch_enable && core.decode_valid && !core.double_fault;
  run_fetch_a: assert property (exec_suspend == !fetch_enable)
    else $error("suspend and fetch disagree");
  serial_order_a: assert property ($rose(serial_enable) |-> freeze && $past(freeze))
    else $error("serial enabled before halt");
  background_entry_opcode_entry_a: assert property (op_run && debug_enabled && core.opcode == OP_BACKGROUND
    |=> freeze && temp_address_reg == SRC_BACKGROUND_ENTRY_OPCODE_CODE) else $error("bad background_entry_opcode entry");
  background_entry_opcode_trap_a: assert property (op_run && !debug_enabled && core.opcode == OP_BACKGROUND
    |=> exc.take && exc.vector == VEC_ILLEGAL && !freeze) else $error("bad background_entry_opcode trap");
  soft_breakpoint_request_n_a: assert property (op_run && core.opcode inside {[OP_SOFT_BREAKPOINT_REQUEST_N_LO:OP_SOFT_BREAKPOINT_REQUEST_N_HI]}
    |=> exc.take && exc.opcode_subst && !freeze) else $error("bad soft breakpoint");
  pipe_adv_a: assert property (fetch_enable && core.insn_start |=> pipe_advance_flag)
    else $error("no pipe advance");
  fetch_mark_a: assert property (fetch_enable && (bus.flush || bus.cycle_end && bus.pipe_load)
    |=> fetch_flush_flag) else $error("no fetch mark");
  dbf_halt_a: assert property (fetch_enable && core.double_fault && !debug_enabled
    |=> (exec_suspend && !freeze)[*8]) else $error("fault did not halt");
  dbf_code_a: assert property (fetch_enable && core.double_fault && debug_enabled
    |=> freeze && temp_address_reg == {$past(core.fault_status_word), SRC_DBF_LOW}) else $error("bad fault code");
  no_ack_a: assert property (freeze |-> !breakpoint_request_n_ack_cycle)
    else $error("ack cycle in debug");
endmodule
`default_nettype wire

// File: sim/dme_bp_host.sv
`timescale 1ns/1ps
`default_nettype none
module dme_bp_host (
  // clock and reset as seen by the development system
  input wire logic clock,
  input wire logic rst,
  // bench wishes
  input wire logic arm_debug,
  input wire logic bp_req,
  // shared breakpoint pin
  output logic     breakpoint_request_n
);
  logic [1:0] after;
  // edges since reset release, saturating
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      after <= 2'h0;
    else if (after != 2'h2)
      after <= after + 2'h1;
  end
  // low all through reset and one edge past it, so released before any bus cycle
  assign breakpoint_request_n = !((arm_debug && (rst || after == 2'h0)) || bp_req);
endmodule
`default_nettype wire

// File: sim/test_debug_mode_entry_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_debug_mode_entry_control
  import dme_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic arm_debug = 1'b0;
  logic bp_req = 1'b0;
  logic resume_cmd = 1'b0;
  logic trace_enable = 1'b0;
  logic trace_flow_only = 1'b0;
  logic pin_n, exec_suspend, fetch_enable, breakpoint_request_n_ack_cycle, freeze, serial_enable, debug_enabled;
  logic pipe_advance_flag, fetch_flush_flag, ack_seen;
  logic [31:0] temp_address_reg;
  dme_core_evt_t core_evt = '0;
  dme_bus_evt_t bus_evt = '0;
  dme_exc_t exc;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  // 125 MHz clock
  always #4 clock = ~clock;
  dme_bp_host i_dme_bp_host (.clock(clock), .rst(rst), .arm_debug(arm_debug), .bp_req(bp_req),
    .breakpoint_request_n(pin_n));
  dme_entry_ctrl i_dme_entry_ctrl (.clock(clock), .rst(rst), .breakpoint_request_n(pin_n), .core(core_evt),
    .bus(bus_evt), .trace_enable(trace_enable), .trace_flow_only(trace_flow_only), .resume_cmd(resume_cmd),
    .exec_suspend(exec_suspend), .fetch_enable(fetch_enable), .breakpoint_request_n_ack_cycle(breakpoint_request_n_ack_cycle), .exc(exc),
    .freeze(freeze), .serial_enable(serial_enable), .debug_enabled(debug_enabled),
    .temp_address_reg(temp_address_reg), .pipe_advance_flag(pipe_advance_flag), .fetch_flush_flag(fetch_flush_flag));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // inputs move 1 ns after the edge so the design samples settled values
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic do_reset(input logic arm);
    arm_debug = arm;
    rst = 1'b1;
    repeat (6) @(posedge clock);
    #1 rst = 1'b0;
    repeat (2) step();
    chk(debug_enabled, arm);
  endtask
  task automatic op(input logic [15:0] code);
    core_evt.decode_valid = 1'b1;
    core_evt.opcode = code;
    step();
    core_evt = '0;
  endtask
  // pin held three edges to clear the synchroniser, then one tagged bus cycle
  task automatic hw_break(input logic prefetch);
    bp_req = 1'b1;
    repeat (3) step();
    bus_evt.cycle_end = 1'b1;
    bus_evt.is_prefetch = prefetch;
    step();
    bus_evt = '0;
    bp_req = 1'b0;
    ack_seen = 1'b0;
    repeat (8)
    begin
      step();
      ack_seen |= (breakpoint_request_n_ack_cycle === 1'b1);
      if (freeze === 1'b1 || exc.take === 1'b1)
        break;
    end
  endtask
  task automatic t_background_entry_opcode_on();
    step();
    op(OP_BACKGROUND);
    chk(freeze, 1);
    chk(fetch_enable, 0);
    chk(temp_address_reg, SRC_BACKGROUND_ENTRY_OPCODE_CODE);
    step();
    chk(serial_enable, 1);
    resume_cmd = 1'b1;
    step();
    resume_cmd = 1'b0;
    chk(freeze, 0);
  endtask
  task automatic t_soft();
    for (int i = 0; i < 8; i++)
    begin
      step();
      op(16'(OP_SOFT_BREAKPOINT_REQUEST_N_LO + i));
      chk(exc.opcode_subst, 1);
      chk(freeze, 0);
    end
  endtask
  task automatic t_track();
    step();
    core_evt.insn_start = 1'b1;
    bus_evt.cycle_end = 1'b1;
    bus_evt.pipe_load = 1'b1;
    step();
    core_evt = '0;
    bus_evt = '0;
    chk({pipe_advance_flag, fetch_flush_flag}, 2'h3);
    step();
    chk({pipe_advance_flag, fetch_flush_flag}, 2'h0);
    bus_evt.flush = 1'b1;
    step();
    bus_evt = '0;
    chk(fetch_flush_flag, 1);
    core_evt.pipe_advance = 1'b1;
    step();
    core_evt = '0;
    chk(pipe_advance_flag, 1);
  endtask
  // trace in both variants, then the two unimplemented-line vectors
  task automatic t_trace();
    step();
    trace_enable = 1'b1;
    core_evt.insn_done = 1'b1;
    step();
    core_evt = '0;
    chk(exc.vector, VEC_TRACE);
    trace_flow_only = 1'b1;
    core_evt.insn_done = 1'b1;
    step();
    core_evt = '0;
    chk(exc.take, 0);
    core_evt.insn_done = 1'b1;
    core_evt.flow_change = 1'b1;
    step();
    core_evt = '0;
    chk(exc.vector, VEC_TRACE);
    trace_enable = 1'b0;
    trace_flow_only = 1'b0;
    op(16'hA123);
    chk(exc.vector, VEC_LINE_A);
    op(16'hF001);
    chk(exc.vector, VEC_LINE_F);
  endtask
  task automatic t_hw_on();
    step();
    bus_evt.cycle_end = 1'b1;
    bus_evt.is_prefetch = 1'b1;
    bp_req = 1'b1;
    repeat (3) step();
    bus_evt = '0;
    bp_req = 1'b0;
    step();
    bus_evt.flush = 1'b1;
    step();
    bus_evt = '0;
    repeat (6) step();
    chk(freeze, 0);
    hw_break(1'b0);
    chk(freeze, 1);
    chk(ack_seen, 0);
    chk(temp_address_reg, SRC_HW_CODE);
    step();
    chk(serial_enable, 1);
    resume_cmd = 1'b1;
    step();
    resume_cmd = 1'b0;
  endtask
  task automatic t_dbf_on();
    step();
    core_evt.double_fault = 1'b1;
    core_evt.fault_status_word = 16'hA5C3;
    step();
    core_evt = '0;
    chk(temp_address_reg, {16'hA5C3, SRC_DBF_LOW});
  endtask
  task automatic t_off();
    step();
    op(OP_BACKGROUND);
    chk(exc.vector, VEC_ILLEGAL);
    hw_break(1'b0);
    chk(exc.vector, VEC_HW_BREAKPOINT);
    step();
    chk(ack_seen | breakpoint_request_n_ack_cycle, 1);
    core_evt.double_fault = 1'b1;
    step();
    core_evt = '0;
    repeat (20) step();
    chk({exec_suspend, freeze}, 2'h2);
    op(OP_BACKGROUND);
    chk(exc.take, 0);
  endtask
  // hang guard, far above the hundred or so cycles the run needs
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial
  begin
    do_reset(1'b1);
    t_background_entry_opcode_on();
    t_soft();
    t_trace();
    t_track();
    t_hw_on();
    t_dbf_on();
    do_reset(1'b0);
    t_off();
    tally_and_finish();
  end
endmodule
bind dme_entry_ctrl dme_entry_props i_dme_entry_props (.clock(clock), .rst(rst), .core(core), .bus(bus),
  .exec_suspend(exec_suspend), .fetch_enable(fetch_enable), .breakpoint_request_n_ack_cycle(breakpoint_request_n_ack_cycle), .exc(exc),
  .freeze(freeze), .serial_enable(serial_enable), .debug_enabled(debug_enabled),
  .temp_address_reg(temp_address_reg), .pipe_advance_flag(pipe_advance_flag), .fetch_flush_flag(fetch_flush_flag));
`default_nettype wire
